// File: drive_status_output_pkg.sv
`default_nettype none
package drive_status_output_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TIMER_TICK_NS = 1000000;     // Timer delays count in ms
   localparam int unsigned MS_CYCLES     = TIMER_TICK_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int N_TERM = 3;                            // Relay 1, relay 2, photo-coupler
   localparam int FC_W   = 6;
   localparam int FREQ_W = 16;                           // 0.01 Hz per LSB
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ------------------------------------------------------------------
   // Function codes
   // ------------------------------------------------------------------
   localparam logic [5:0] FC_RUN       = 6'h00;
   localparam logic [5:0] FC_FAULT     = 6'h01;
   localparam logic [5:0] FC_AGREE     = 6'h02;
   localparam logic [5:0] FC_SET_AGREE = 6'h03;
   localparam logic [5:0] FC_DET1      = 6'h04;
   localparam logic [5:0] FC_DET2      = 6'h05;
   localparam logic [5:0] FC_RESTART   = 6'h06;
   localparam logic [5:0] FC_BASEBLOCK = 6'h09;
   localparam logic [5:0] FC_OVER_TQ   = 6'h0c;
   localparam logic [5:0] FC_BRAKE     = 6'h0e;
   localparam logic [5:0] FC_LC_SRC    = 6'h12;
   localparam logic [5:0] FC_LC_REQ    = 6'h13;
   localparam logic [5:0] FC_ZERO_SPD  = 6'h14;
   localparam logic [5:0] FC_READY     = 6'h15;
   localparam logic [5:0] FC_UNDERVOLT = 6'h16;
   localparam logic [5:0] FC_LOCAL_RUN = 6'h17;
   localparam logic [5:0] FC_LOCAL_REF = 6'h18;
   localparam logic [5:0] FC_UNDER_TQ  = 6'h19;
   localparam logic [5:0] FC_REF_LOSS  = 6'h1a;
   localparam logic [5:0] FC_TIMER     = 6'h1b;
   localparam logic [5:0] FC_TRAV_UP   = 6'h1c;
   localparam logic [5:0] FC_TRAV      = 6'h1d;
   localparam logic [5:0] FC_MOTOR2    = 6'h1e;
   localparam logic [5:0] FC_ZSERVO    = 6'h1f;
   localparam logic [5:0] FC_COMM      = 6'h20;

   // ------------------------------------------------------------------
   // Sources and control modes
   // ------------------------------------------------------------------
   localparam logic [1:0] SRC_KEYPAD = 2'h0;
   localparam logic [1:0] SRC_LC     = 2'h3;
   localparam logic [2:0] MODE_SLV   = 3'h2;
   localparam logic [2:0] MODE_SV    = 3'h3;
   localparam logic [2:0] MODE_PMSV  = 3'h4;

   // ------------------------------------------------------------------
   // Register word indices (byte address = 4 * index)
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_SEL    = 6'h00;
   localparam logic [5:0] IDX_DET    = 6'h01;
   localparam logic [5:0] IDX_LIMITS = 6'h02;
   localparam logic [5:0] IDX_BRAKE  = 6'h03;
   localparam logic [5:0] IDX_SRC    = 6'h04;
   localparam logic [5:0] IDX_COMM   = 6'h05;
   localparam logic [5:0] IDX_TIMER  = 6'h06;
   localparam logic [5:0] IDX_STATUS = 6'h07;
   localparam int SEL_STRIDE   = 8;                      // Selector i at bit 8*i
   localparam int SRC_REF_LSB  = 2;
   localparam int SRC_LOSS_BIT = 4;
   localparam int SRC_RATIO_LSB = 8;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [5:0]  RST_SEL0  = FC_RUN;
   localparam logic [5:0]  RST_SEL1  = FC_FAULT;
   localparam logic [5:0]  RST_SEL2  = FC_READY;
   localparam logic [15:0] RST_WIDTH = 16'h0064;         // 1.00 Hz
   localparam logic [7:0]  RST_RATIO = 8'h50;

   // Drive conditions that one terminal may follow
   typedef struct packed {
      logic run, fault, agree, set_agree, det1, det2, restart, baseblock;
      logic over_tq, brake, lc_src, zero_spd, ready, undervolt;
      logic local_run, local_ref, under_tq, ref_loss, timer, trav_up, trav;
      logic motor2, zservo;
   } cond_s;

endpackage : drive_status_output_pkg
`default_nettype wire

// File: drive_status_output_selector.sv
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Operation
// [R1] Code 0: on while run command on or output frequency nonzero.
// [R2] Code 1: on during any fault except the two communication errors.
// [R3] Code 2: on while output frequency within detection width of reference.
// [R4] Code 3: on while output frequency within level plus or minus width.
// [R5] Code 4: on at level plus width rising, off below level.
// [R6] Code 5: complement of code 4 hysteresis.
// [R7] Code 6: on during automatic restart.
// [R8] Code 9: on during baseblock.
// [R9] Code 12 follows over-torque, code 25 follows low-torque detection.
// [R10] Code 18: on while run command source equals the logic controller.
// [R11] Code 19: output taken from the logic controller request.
// [R12] Code 20: on while output frequency below minimum output frequency.
// [R13] Code 21: on when no fault and drive ready.
// [R14] Code 22: on while bus voltage below low-voltage level.
// [R15] Code 23: on in local run source; run lamp lit in remote.
// [R16] Code 24: on in local reference source; reference lamp lit in remote.
// [R17] Code 26: on on reference loss; loss action and ratio exported.
// [R18] Code 27: driven by timer with on and off delays.
// [R19] Codes 28, 29: traverse up and traverse; blocked in two vector modes.
// [R20] Code 30: on while motor 2 selected.
// [R21] Code 31: zero servo locked, closed-loop vector modes only.
// [R22] Code 32: output set over the communication register.
// [R23] Code 14: brake on at release level rising, off at operation level falling.
// [R24] Each terminal has its own selector; reserved codes hold it off.
module drive_status_output_selector
   import drive_status_output_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Drive status
   input  wire logic                   run_cmd,
   input  wire logic [FREQ_W-1:0]      out_freq,
   input  wire logic [FREQ_W-1:0]      freq_ref,
   input  wire logic [FREQ_W-1:0]      dc_bus_volt,
   input  wire logic                   fault_any,
   input  wire logic                   comm_error_a,
   input  wire logic                   comm_error_b,
   input  wire logic                   drive_ready,
   input  wire logic                   restart_active,
   input  wire logic                   baseblock_active,
   input  wire logic                   over_torque,
   input  wire logic                   under_torque,
   input  wire logic                   local_select_in,
   input  wire logic                   ref_lost,
   input  wire logic                   timer_in,
   input  wire logic                   traverse_up,
   input  wire logic                   traverse_active,
   input  wire logic                   motor2_sel,
   input  wire logic                   zero_servo_en,
   input  wire logic                   zero_servo_locked,
   input  wire logic [2:0]             control_mode,
   input  wire logic [N_TERM-1:0]      embedded_logic_controller_req,
   // Terminals and lamps
   output logic [N_TERM-1:0]           term_out,
   output logic                        run_source_lamp,
   output logic                        ref_source_lamp,
   output logic                        ref_loss_decel,
   output logic [7:0]                  ref_loss_ratio
);

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [N_TERM-1:0][FC_W-1:0] sel;
      logic [15:0] level, width, fmin, lowv, brel, bop, ton, toff, prev;
      logic [1:0]  run_src, ref_src;
      logic        loss_act;
      logic [7:0]  ratio;
      logic [N_TERM-1:0] comm, term;
      logic        det1, brake, tmr, run_lamp, ref_lamp;
      logic [19:0] presc;
      logic [15:0] tcnt;
      logic        wr_pend, ready;
      logic [5:0]  waddr;
      logic [31:0] rdata;
   } st_s;

   st_s   st_r;
   st_s   st_nxt;
   cond_s c;
   logic  slv_mode;
   logic  sensored_vector_mode;
   logic  permanent_magnet_vector_mode;
   logic  addr_ok;

   // ---------------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------------
   // Distance between two frequencies, used by both agree windows
   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a >= b) ? a - b : b - a;
   endfunction : absdiff

   // Condition picked by one terminal selector
   function automatic logic pick(input logic [5:0] fc, input cond_s k,
                                 input logic lc, input logic cm);
      unique case (fc)
         FC_RUN:       pick = k.run;                       // see [R1]
         FC_FAULT:     pick = k.fault;                     // see [R2]
         FC_AGREE:     pick = k.agree;                     // see [R3]
         FC_SET_AGREE: pick = k.set_agree;                 // see [R4]
         FC_DET1:      pick = k.det1;                      // see [R5]
         FC_DET2:      pick = k.det2;                      // see [R6]
         FC_RESTART:   pick = k.restart;                   // see [R7]
         FC_BASEBLOCK: pick = k.baseblock;                 // see [R8]
         FC_OVER_TQ:   pick = k.over_tq;                   // see [R9]
         FC_UNDER_TQ:  pick = k.under_tq;                  // see [R9]
         FC_BRAKE:     pick = k.brake;                     // see [R23]
         FC_LC_SRC:    pick = k.lc_src;                    // see [R10]
         FC_LC_REQ:    pick = lc;                          // see [R11]
         FC_ZERO_SPD:  pick = k.zero_spd;                  // see [R12]
         FC_READY:     pick = k.ready;                     // see [R13]
         FC_UNDERVOLT: pick = k.undervolt;                 // see [R14]
         FC_LOCAL_RUN: pick = k.local_run;                 // see [R15]
         FC_LOCAL_REF: pick = k.local_ref;                 // see [R16]
         FC_REF_LOSS:  pick = k.ref_loss;                  // see [R17]
         FC_TIMER:     pick = k.timer;                     // see [R18]
         FC_TRAV_UP:   pick = k.trav_up;                   // see [R19]
         FC_TRAV:      pick = k.trav;                      // see [R19]
         FC_MOTOR2:    pick = k.motor2;                    // see [R20]
         FC_ZSERVO:    pick = k.zservo;                    // see [R21]
         FC_COMM:      pick = cm;                          // see [R22]
         default:      pick = 1'b0;                        // Reserved, see [R24]
      endcase
   endfunction : pick

   // Register read mux; fed the next state so a read sees a write just done
   function automatic logic [31:0] read_word(input st_s s, input logic [5:0] idx);
      read_word = 32'h0000_0000;
      unique case (idx)
         IDX_SEL:    read_word = {8'h00, 2'h0, s.sel[2], 2'h0, s.sel[1], 2'h0, s.sel[0]};
         IDX_DET:    read_word = {s.width, s.level};
         IDX_LIMITS: read_word = {s.lowv, s.fmin};
         IDX_BRAKE:  read_word = {s.bop, s.brel};
         IDX_SRC:    read_word = {16'h0000, s.ratio, 3'h0, s.loss_act, s.ref_src, s.run_src};
         IDX_COMM:   read_word = {29'h0, s.comm};
         IDX_TIMER:  read_word = {s.toff, s.ton};
         IDX_STATUS: read_word = {24'h0, s.ref_lamp, s.run_lamp, s.tmr, s.brake, s.det1,
                                  s.term};
         default:    read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   // ---------------------------------------------------------------------
   // Control mode decode
   // ---------------------------------------------------------------------
   assign slv_mode                     = (control_mode == MODE_SLV);
   assign sensored_vector_mode         = (control_mode == MODE_SV);
   assign permanent_magnet_vector_mode = (control_mode == MODE_PMSV);
   assign addr_ok = hsel & htrans[1] & hready;

   // ---------------------------------------------------------------------
   // Next state: bus, hysteresis, brake, timer, terminals
   // ---------------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.ready   = 1'b1;
      st_nxt.wr_pend = 1'b0;

      // Write data phase; non-word writes were dropped in the address phase
      if (st_r.wr_pend) begin
         unique case (st_r.waddr)
            IDX_SEL: begin
               for (int i = 0; i < N_TERM; i++) begin
                  st_nxt.sel[i] = hwdata[i*SEL_STRIDE +: FC_W];  // see [R24]
               end
            end
            IDX_DET:    {st_nxt.width, st_nxt.level} = hwdata;
            IDX_LIMITS: {st_nxt.lowv, st_nxt.fmin} = hwdata;
            IDX_BRAKE:  {st_nxt.bop, st_nxt.brel} = hwdata;
            IDX_SRC: begin
               st_nxt.run_src  = hwdata[1:0];
               st_nxt.ref_src  = hwdata[SRC_REF_LSB +: 2];
               st_nxt.loss_act = hwdata[SRC_LOSS_BIT];
               st_nxt.ratio    = hwdata[SRC_RATIO_LSB +: 8];
            end
            IDX_COMM:   st_nxt.comm = hwdata[N_TERM-1:0];
            IDX_TIMER:  {st_nxt.toff, st_nxt.ton} = hwdata;
            default: ;                                     // Unmapped or read-only
         endcase
      end

      // Address phase
      if (addr_ok && hwrite && hsize == HSIZE_WORD) begin
         st_nxt.wr_pend = 1'b1;
         st_nxt.waddr   = haddr[7:2];
      end

      // Frequency detection hysteresis
      if ({1'b0, out_freq} >= {1'b0, st_nxt.level} + {1'b0, st_nxt.width}) begin
         st_nxt.det1 = 1'b1;                               // see [R5]
      end else if (out_freq < st_nxt.level) begin
         st_nxt.det1 = 1'b0;                               // see [R5]
      end

      // Brake: rising edge of speed sets, falling clears
      if (out_freq > st_r.prev && out_freq >= st_nxt.brel) begin
         st_nxt.brake = 1'b1;                              // see [R23]
      end else if (out_freq < st_r.prev && out_freq <= st_nxt.bop) begin
         st_nxt.brake = 1'b0;                              // see [R23]
      end
      st_nxt.prev = out_freq;

      // Timer: input must differ for the full delay before the output follows
      if (timer_in == st_r.tmr) begin
         st_nxt.tcnt  = 16'h0000;
         st_nxt.presc = 20'h00000;
      end else if (st_r.tcnt >= (st_r.tmr ? st_nxt.toff : st_nxt.ton)) begin
         st_nxt.tmr   = timer_in;                          // see [R18]
         st_nxt.tcnt  = 16'h0000;
         st_nxt.presc = 20'h00000;
      end else if (st_r.presc == 20'(MS_CYCLES_P - 1)) begin
         st_nxt.presc = 20'h00000;
         st_nxt.tcnt  = st_r.tcnt + 16'h0001;
      end else begin
         st_nxt.presc = st_r.presc + 20'h00001;
      end

      // Conditions
      c.run       = run_cmd | (out_freq != '0);            // see [R1]
      c.fault     = fault_any & ~comm_error_a & ~comm_error_b;  // see [R2]
      c.agree     = absdiff(out_freq, freq_ref) <= st_nxt.width;  // see [R3]
      c.set_agree = absdiff(out_freq, st_nxt.level) <= st_nxt.width;  // see [R4]
      c.det1      = st_nxt.det1;
      c.det2      = ~st_nxt.det1;                          // see [R6]
      c.restart   = restart_active;
      c.baseblock = baseblock_active;
      c.over_tq   = over_torque;
      c.under_tq  = under_torque;
      c.brake     = st_nxt.brake;
      c.lc_src    = (st_nxt.run_src == SRC_LC);            // see [R10]
      c.zero_spd  = out_freq < st_nxt.fmin;                // see [R12]
      c.ready     = ~fault_any & drive_ready;              // see [R13]
      c.undervolt = dc_bus_volt < st_nxt.lowv;             // see [R14]
      c.local_run = (st_nxt.run_src == SRC_KEYPAD) | local_select_in;  // see [R15]
      c.local_ref = (st_nxt.ref_src == SRC_KEYPAD) | local_select_in;  // see [R16]
      c.ref_loss  = ref_lost;                              // see [R17]
      c.timer     = st_nxt.tmr;
      // Traverse is meaningless in the two induction vector modes
      c.trav_up   = traverse_up & ~slv_mode & ~sensored_vector_mode;  // see [R19]
      c.trav      = traverse_active & ~slv_mode & ~sensored_vector_mode;  // see [R19]
      c.motor2    = motor2_sel;                            // see [R20]
      c.zservo    = zero_servo_en & zero_servo_locked
                    & (sensored_vector_mode | permanent_magnet_vector_mode);  // see [R21]

      // Terminals, each with its own selector
      for (int i = 0; i < N_TERM; i++) begin
         st_nxt.term[i] = pick(st_nxt.sel[i], c, embedded_logic_controller_req[i],
                               st_nxt.comm[i]);            // see [R24]
      end
      st_nxt.run_lamp = ~c.local_run;                      // see [R15]
      st_nxt.ref_lamp = ~c.local_ref;                      // see [R16]

      // Read data captured in the address phase, zero wait states
      if (addr_ok && !hwrite) begin
         st_nxt.rdata = read_word(st_nxt, haddr[7:2]);
      end
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r        <= '0;
         st_r.sel[0] <= RST_SEL0;
         st_r.sel[1] <= RST_SEL1;
         st_r.sel[2] <= RST_SEL2;
         st_r.width  <= RST_WIDTH;
         st_r.ratio  <= RST_RATIO;
         st_r.ready  <= 1'b1;
         st_r.run_lamp <= 1'b0;
         st_r.ref_lamp <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register, hresp tied low
   assign hreadyout       = st_r.ready;
   assign hresp           = 1'b0;
   assign hrdata          = st_r.rdata;
   assign term_out        = st_r.term;
   assign run_source_lamp = st_r.run_lamp;
   assign ref_source_lamp = st_r.ref_lamp;
   assign ref_loss_decel  = ~st_r.loss_act;               // see [R17]
   assign ref_loss_ratio  = st_r.ratio;                   // see [R17]

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence brake_rise_s;
      st_r.sel[0] == FC_BRAKE && out_freq > st_r.prev && out_freq >= st_r.brel
      && !st_r.wr_pend;
   endsequence

   sequence timer_held_s;
      (st_r.sel[1] == FC_TIMER && !st_r.wr_pend && st_r.ton == 16'h0000
       && timer_in && !st_r.tmr);
   endsequence

   running_term_a: assert property (                       // see [R1]
      st_r.sel[0] == FC_RUN && !st_r.wr_pend && run_cmd |=> term_out[0])
      else $error("run code did not drive terminal on");

   comm_fault_a: assert property (                         // see [R2]
      st_r.sel[1] == FC_FAULT && !st_r.wr_pend && comm_error_a |=> !term_out[1])
      else $error("communication error drove fault terminal");

   det_hyst_a: assert property (                           // see [R5]
      st_r.sel[0] == FC_DET1 && !st_r.wr_pend && out_freq < st_r.level
      |=> !term_out[0] && !st_r.det1)
      else $error("detection 1 stayed on below level");

   det2_compl_a: assert property (                         // see [R6]
      st_r.sel[1] == FC_DET2 && !st_r.wr_pend |=> term_out[1] == !st_r.det1)
      else $error("detection 2 not complement of detection 1");

   reserved_off_a: assert property (                       // see [R24]
      !st_r.wr_pend && (st_r.sel[1] == 6'h07 || st_r.sel[1] == 6'h0d
      || st_r.sel[1] == 6'h10) |=> !term_out[1])
      else $error("reserved code drove terminal");

   zero_speed_a: assert property (                         // see [R12]
      st_r.sel[2] == FC_ZERO_SPD && !st_r.wr_pend
      |=> term_out[2] == ($past(out_freq) < st_r.fmin))
      else $error("zero speed output wrong");

   ready_term_a: assert property (                         // see [R13]
      st_r.sel[2] == FC_READY && !st_r.wr_pend && comm_error_b && fault_any
      |=> !term_out[2])
      else $error("ready asserted with a fault");

   brake_on_a: assert property (brake_rise_s |=> term_out[0] && st_r.brake)  // see [R23]
      else $error("brake did not release on rising speed");

   timer_on_a: assert property (timer_held_s |=> term_out[1] && st_r.tmr)  // see [R18]
      else $error("timer output not on with zero delay");

   servo_mode_a: assert property (                         // see [R21]
      st_r.sel[2] == FC_ZSERVO && !st_r.wr_pend && (slv_mode || control_mode == 3'h0)
      |=> !term_out[2])
      else $error("zero servo output outside closed-loop modes");

   local_lamp_a: assert property (                         // see [R15]
      !st_r.wr_pend && st_r.run_src == SRC_KEYPAD |=> !run_source_lamp)
      else $error("run lamp lit in local mode");

endmodule : drive_status_output_selector
`default_nettype wire

// File: relay_contact_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------
// Normally open terminal contacts
// ------------------------------------
module relay_contact_model
   import drive_status_output_pkg::*;
(
   // Coil drive
   input  wire logic [N_TERM-1:0] coil,
   // Contact state
   output logic      [N_TERM-1:0] closed
);
   // Closed while energised; no bounce modelled
   assign closed = coil;
endmodule : relay_contact_model
`default_nettype wire

// File: drive_status_output_selector_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module drive_status_output_selector_tb_top
   import drive_status_output_pkg::*;
;
   logic              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, lamp;
   logic              rlamp, decel, hresp;
   logic [2:0]        mode = 3'h0, lcr = 3'h0;
   logic [7:0]        ratio;
   logic [1:0]        htrans = 2'h0;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [16:0]       s = 17'h0;
   logic [15:0]       fq = 16'h0;
   logic [N_TERM-1:0] to, closed;
   logic [5:0]        rsv [9] = '{6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0d, 6'h0f, 6'h10, 6'h11, 6'h21};
   int                fails = 0, comparisons = 0;
   wire logic [11:0]  side = {hresp, lamp, rlamp, decel, ratio};
   // ------------------------------------
   // Design, contacts and clock
   // ------------------------------------
   drive_status_output_selector #(.MS_CYCLES_P(4)) u_dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout,
      .hresp(hresp), .hrdata, .run_cmd(s[0]), .fault_any(s[1]), .comm_error_a(s[2]),
      .comm_error_b(s[3]), .drive_ready(s[4]), .restart_active(s[5]),
      .baseblock_active(s[6]), .over_torque(s[7]), .under_torque(s[8]),
      .local_select_in(s[9]), .ref_lost(s[10]), .timer_in(s[11]), .traverse_up(s[12]),
      .traverse_active(s[13]), .motor2_sel(s[14]), .zero_servo_en(s[15]),
      .zero_servo_locked(s[16]), .out_freq(fq), .freq_ref(fq), .dc_bus_volt(fq),
      .control_mode(mode), .embedded_logic_controller_req(lcr), .term_out(to),
      .run_source_lamp(lamp), .ref_source_lamp(rlamp), .ref_loss_decel(decel),
      .ref_loss_ratio(ratio));
   relay_contact_model u_contacts (.coil(to), .closed(closed));
   initial begin
      forever #4 hclk = ~hclk;
   end
   // One AHB single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // Status in, two edges for the registered terminals, then contacts
   task automatic sv(input logic [16:0] ns, input logic [15:0] nf, input logic [2:0] e);
      s <= ns;
      fq <= nf;
      repeat (2) @(posedge hclk);
      `CHK(closed, e)
   endtask : sv
   task automatic results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   // Hang guard, far beyond the roughly 100 cycles needed
   initial begin
      #100000;
      fails++;
      results();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, 32'h0, 32'h0);
      `CHK(rd, 32'h00150100)
      `CHK(side, 12'h150)
      sv(17'h00011, 16'h0, 3'b101);
      sv(17'h0001f, 16'h0, 3'b001);
      sv(17'h00013, 16'h0, 3'b011);
      $display("test status done");
      bus(1'b1, 32'h0, 32'h00140504);
      bus(1'b1, 32'h4, 32'h00640064);
      bus(1'b1, 32'h8, 32'h00000060);
      sv(17'h0, 16'h00c8, 3'b001);
      sv(17'h0, 16'h0064, 3'b001);
      sv(17'h0, 16'h0063, 3'b010);
      sv(17'h0, 16'h0050, 3'b110);
      $display("test detection done");
      foreach (rsv[i]) begin
         bus(1'b1, 32'h0, {10'h0, rsv[i], 2'h0, rsv[i], 2'h0, rsv[i]});
         sv(17'h1ffff, 16'h0, 3'b000);
      end
      $display("test reserved done");
      // Brake on relay 1, timer on relay 2, zero servo on the photo-coupler
      bus(1'b1, 32'h0, 32'h001f1b0e);
      sv(17'h0, 16'h0, 3'b000);
      sv(17'h18800, 16'h0010, 3'b011);
      mode <= 3'h3;
      sv(17'h18000, 16'h0010, 3'b101);
      sv(17'h0, 16'h0, 3'b000);
      $display("test brake timer servo done");
      bus(1'b1, 32'h0, 32'h00132020);
      bus(1'b1, 32'h14, 32'h3);
      lcr <= 3'h4;
      sv(17'h0, 16'h0, 3'b111);
      bus(1'b1, 32'h0, 32'h001a1817);
      bus(1'b1, 32'h10, 32'h3315);
      sv(17'h0, 16'h0, 3'b000);
      `CHK(side, 12'h633)
      sv(17'h00600, 16'h0, 3'b111);
      `CHK(side, 12'h033)
      bus(1'b0, 32'h40, 32'h0);
      `CHK(rd, 32'h0)
      $display("test control done");
      results();
   end
endmodule : drive_status_output_selector_tb_top
`default_nettype wire
